// ### power_state_pkg.sv
// constants shared by the sleep and management-mode control block
// assumes one 10 MHz clock and a synchronous active-low reset
//
// How it works
// - halt request: grant, acknowledge, gate core clocks
// - halt release: restart all clocks, resume, interrupts
// - sleep request during grant enters sleep
// - sleep stops every unit clock, pll runs
// - sleep ignores snoops and interrupts
// - sleep sees only sleep and reset, halt is not looked at
// - sleep release returns to grant state
// - back in grant: bus, interrupt clocks only
// - accepted interrupt saves state, enters management mode
// - entering management mode issues acknowledge transaction
// - after acknowledge, fetch from management handler
package power_state_pkg;

    // -------------------------------------------------------------
    // power and management states
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN,
        ST_GRANT,
        ST_SLEEP,
        ST_SAVE,
        ST_ACK,
        ST_HANDLER
    } power_state_e;

    // -------------------------------------------------------------
    // clock gate bits and counts
    // -------------------------------------------------------------
    localparam int          CLK_CORE_BIT    = 0;
    localparam int          CLK_BUS_BIT     = 1;
    localparam int          CLK_INTR_BIT    = 2;
    localparam logic [2:0]  CLK_ALL         = 3'h7;
    localparam logic [2:0]  CLK_BUS_INTR    = 3'h6;
    localparam logic [2:0]  CLK_NONE        = 3'h0;
    localparam logic [2:0]  CLK_RESET       = 3'h7;
    localparam logic [3:0]  SAVE_CYCLES     = 4'h8;
    localparam int          SYNC_STAGES     = 2;

endpackage : power_state_pkg

// ### sync_two_flop.sv
// two-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to the clock
`timescale 1ns/1ns
`default_nettype none
module sync_two_flop
    import power_state_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // level
    input  wire logic async_in,
    input  wire logic reset_val_in,
    output var  logic sync_out
);
    logic [SYNC_STAGES-1:0] stage_reg;

    // first stage feeds only the second; reset level comes from a tied port
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            stage_reg <= {SYNC_STAGES{reset_val_in}};
        end else begin
            stage_reg <= {stage_reg[SYNC_STAGES-2:0], async_in};
        end
    end

    assign sync_out = stage_reg[SYNC_STAGES-1];
endmodule : sync_two_flop
`default_nettype wire

// ### sleep_smm_ctrl.sv
// sleep state and management-mode entry control of the core
// assumes request pins are asynchronous, active low, held high at reset
`timescale 1ns/1ns
`default_nettype none
module sleep_smm_ctrl
    import power_state_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       nrst_in,
    // system request pins
    input  wire logic       sleep_request_n_in,
    input  wire logic       core_clock_halt_request_n_in,
    input  wire logic       system_mgmt_interrupt_n_in,
    // core side inputs
    input  wire logic       snoop_req_in,
    input  wire logic       intr_req_in,
    input  wire logic       handler_exit_in,
    // clock enables towards core units
    output var  logic       core_clk_en_out,
    output var  logic       bus_clk_en_out,
    output var  logic       intr_clk_en_out,
    output var  logic       pll_run_out,
    // bus transactions and core control
    output var  logic       grant_ack_out,
    output var  logic       mgmt_ack_out,
    output var  logic       save_state_out,
    output var  logic       handler_fetch_out,
    output var  logic       system_management_mode_out,
    output var  logic       snoop_accept_out,
    output var  logic       intr_accept_out,
    output var  logic       intr_service_out,
    output var  logic       sleeping_out
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic sleep_req_n_s;
    logic halt_req_n_s;
    logic mgmt_req_n_s;

    sync_two_flop u_sync_sleep (
        .clk_in       (core_clk_in),
        .nrst_in      (nrst_in),
        .async_in     (sleep_request_n_in),
        .reset_val_in (1'b1),
        .sync_out     (sleep_req_n_s)
    );
    sync_two_flop u_sync_halt (
        .clk_in       (core_clk_in),
        .nrst_in      (nrst_in),
        .async_in     (core_clock_halt_request_n_in),
        .reset_val_in (1'b1),
        .sync_out     (halt_req_n_s)
    );
    // management request arrives with no relation to the core clock
    sync_two_flop u_sync_mgmt (
        .clk_in       (core_clk_in),
        .nrst_in      (nrst_in),
        .async_in     (system_mgmt_interrupt_n_in),
        .reset_val_in (1'b1),
        .sync_out     (mgmt_req_n_s)
    );

    logic sleep_req;
    logic halt_req;
    logic mgmt_req;
    logic mgmt_req_d_reg;
    logic mgmt_edge;
    assign sleep_req = ~sleep_req_n_s;
    assign halt_req  = ~halt_req_n_s;
    assign mgmt_req  = ~mgmt_req_n_s;
    assign mgmt_edge = mgmt_req & ~mgmt_req_d_reg;

    // ---------------------------------------------------------------
    // state machine
    // ---------------------------------------------------------------
    power_state_e state_reg;
    power_state_e state_next;
    logic [3:0]   save_cnt_reg;
    logic         mgmt_pend_reg;
    logic         intr_pend_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (halt_req) begin
                    state_next = ST_GRANT;
                end else if (mgmt_pend_reg) begin
                    state_next = ST_SAVE;
                end
            end
            ST_GRANT: begin
                if (sleep_req) begin
                    state_next = ST_SLEEP;
                end else if (!halt_req) begin
                    state_next = ST_RUN;
                end
            end
            ST_SLEEP: begin
                // only the sleep pin moves us out; the system keeps halt asserted
                if (!sleep_req) begin
                    state_next = ST_GRANT;
                end
            end
            ST_SAVE: begin
                if (save_cnt_reg == SAVE_CYCLES - 4'h1) begin
                    state_next = ST_ACK;
                end
            end
            ST_ACK: begin
                state_next = ST_HANDLER;
            end
            ST_HANDLER: begin
                if (handler_exit_in) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            save_cnt_reg <= 4'h0;
        end else if (state_reg == ST_SAVE) begin
            save_cnt_reg <= save_cnt_reg + 4'h1;
        end else begin
            save_cnt_reg <= 4'h0;
        end
    end

    // ---------------------------------------------------------------
    // pending management and interrupt requests
    // ---------------------------------------------------------------
    // pins other than sleep, halt and reset are not looked at in sleep
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            mgmt_req_d_reg <= 1'b0;
            mgmt_pend_reg  <= 1'b0;
        end else begin
            mgmt_req_d_reg <= mgmt_req;
            if (mgmt_edge && state_reg != ST_SLEEP) begin
                mgmt_pend_reg <= 1'b1;
            end else if (state_reg == ST_RUN && !halt_req) begin
                mgmt_pend_reg <= 1'b0;
            end
        end
    end

    // grant state may latch interrupts; sleep takes none
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            intr_pend_reg <= 1'b0;
        end else if (intr_req_in && state_reg != ST_SLEEP) begin
            intr_pend_reg <= 1'b1;
        end else if (state_reg == ST_RUN && !halt_req) begin
            // cleared only where it is serviced, so a halt cannot swallow it
            intr_pend_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    logic [2:0] clk_en_next;
    always_comb begin
        case (state_next)
            ST_GRANT: clk_en_next = CLK_BUS_INTR;
            ST_SLEEP: clk_en_next = CLK_NONE;
            default:  clk_en_next = CLK_ALL;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            core_clk_en_out <= CLK_RESET[CLK_CORE_BIT];
            bus_clk_en_out  <= CLK_RESET[CLK_BUS_BIT];
            intr_clk_en_out <= CLK_RESET[CLK_INTR_BIT];
            pll_run_out     <= 1'b1;
        end else begin
            core_clk_en_out <= clk_en_next[CLK_CORE_BIT];
            bus_clk_en_out  <= clk_en_next[CLK_BUS_BIT];
            intr_clk_en_out <= clk_en_next[CLK_INTR_BIT];
            pll_run_out     <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            grant_ack_out              <= 1'b0;
            mgmt_ack_out               <= 1'b0;
            save_state_out             <= 1'b0;
            handler_fetch_out          <= 1'b0;
            system_management_mode_out <= 1'b0;
            sleeping_out               <= 1'b0;
        end else begin
            grant_ack_out     <= (state_reg == ST_RUN) && (state_next == ST_GRANT);
            mgmt_ack_out      <= (state_next == ST_ACK) && (state_reg == ST_SAVE);
            save_state_out    <= (state_next == ST_SAVE);
            handler_fetch_out <= (state_next == ST_HANDLER);
            system_management_mode_out <= (state_next == ST_ACK)
                                       || (state_next == ST_HANDLER);
            sleeping_out      <= (state_next == ST_SLEEP);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            snoop_accept_out <= 1'b0;
            intr_accept_out  <= 1'b0;
            intr_service_out <= 1'b0;
        end else begin
            snoop_accept_out <= snoop_req_in && (state_reg != ST_SLEEP);
            intr_accept_out  <= intr_req_in && (state_reg != ST_SLEEP);
            // pending interrupts are serviced once clocks are back
            intr_service_out <= intr_pend_reg && (state_reg == ST_RUN)
                                && !halt_req;
        end
    end

endmodule : sleep_smm_ctrl
`default_nettype wire

// ### sleep_smm_ctrl_sva.sv
// checker for the sleep and management-mode control block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module sleep_smm_ctrl_sva (
    input wire logic core_clk_in, nrst_in, sleep_request_n_in, core_clock_halt_request_n_in,
    input wire logic system_mgmt_interrupt_n_in, core_clk_en_out, bus_clk_en_out,
    input wire logic intr_clk_en_out, pll_run_out, grant_ack_out, mgmt_ack_out,
    input wire logic save_state_out, handler_fetch_out, system_management_mode_out,
    input wire logic snoop_accept_out, intr_accept_out, sleeping_out
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    a_grant_gates_core: assert property (grant_ack_out |->
        !core_clk_en_out && bus_clk_en_out && intr_clk_en_out) else $error("grant bad gates");
    a_grant_ack_pulse: assert property (grant_ack_out |=> !grant_ack_out)
        else $error("grant ack too long");
    a_halt_release_run: assert property (core_clock_halt_request_n_in [*5] |->
        core_clk_en_out) else $error("core clock not restarted");
    a_sleep_from_grant: assert property ($rose(sleeping_out) |->
        $past(!core_clk_en_out && bus_clk_en_out)) else $error("sleep not from grant");
    a_sleep_gates_all: assert property (sleeping_out |->
        !(core_clk_en_out || bus_clk_en_out || intr_clk_en_out) && pll_run_out)
        else $error("sleep gates wrong");
    a_sleep_is_deaf: assert property (sleeping_out |-> !save_state_out ##1
        (!snoop_accept_out && !intr_accept_out)) else $error("taken in sleep");
    a_sleep_hold: assert property (!sleep_request_n_in [*4] ##0 sleeping_out |=>
        sleeping_out) else $error("sleep left early");
    a_sleep_exit_grant: assert property ($fell(sleeping_out) |->
        !core_clk_en_out && bus_clk_en_out && intr_clk_en_out) else $error("bad sleep exit");
    a_mgmt_synced: assert property ($rose(save_state_out) |->
        $past(!system_mgmt_interrupt_n_in, 3)) else $error("save without request");
    a_save_then_ack: assert property ($rose(save_state_out) |-> save_state_out [*8] ##1
        (!save_state_out && mgmt_ack_out && system_management_mode_out))
        else $error("save length or ack wrong");
    a_ack_then_fetch: assert property (mgmt_ack_out |=>
        handler_fetch_out && !mgmt_ack_out) else $error("no handler fetch");
endmodule : sleep_smm_ctrl_sva
bind sleep_smm_ctrl sleep_smm_ctrl_sva chk (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .sleep_request_n_in(sleep_request_n_in),
    .core_clock_halt_request_n_in(core_clock_halt_request_n_in),
    .system_mgmt_interrupt_n_in(system_mgmt_interrupt_n_in),
    .core_clk_en_out(core_clk_en_out), .bus_clk_en_out(bus_clk_en_out),
    .intr_clk_en_out(intr_clk_en_out), .pll_run_out(pll_run_out),
    .grant_ack_out(grant_ack_out), .mgmt_ack_out(mgmt_ack_out),
    .save_state_out(save_state_out), .handler_fetch_out(handler_fetch_out),
    .system_management_mode_out(system_management_mode_out),
    .snoop_accept_out(snoop_accept_out), .intr_accept_out(intr_accept_out),
    .sleeping_out(sleeping_out));
`default_nettype wire

// ### system_logic_model.sv
// system logic driving the sleep, halt and management pins
// assumes commands from the bench, grant ack from the block
`timescale 1ns/1ns
`default_nettype none
module system_logic_model (
    input  wire logic core_clk_in, halt_cmd_in, sleep_cmd_in, smi_cmd_in, grant_ack_in,
    output var  logic sleep_request_n_out = 1'h1,
    output var  logic core_clock_halt_request_n_out = 1'h1,
    output var  logic system_mgmt_interrupt_n_out = 1'h1
);
    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic granted_reg = 1'h0;
    always @(posedge core_clk_in) begin
        if (grant_ack_in)
            granted_reg <= 1'h1;
        else if (core_clock_halt_request_n_out)
            granted_reg <= 1'h0;
        // sleep only once granted; halt kept while sleep is low
        sleep_request_n_out <= !(sleep_cmd_in && granted_reg);
        core_clock_halt_request_n_out <= !halt_cmd_in && sleep_request_n_out;
        // off-edge on purpose: the block must synchronise it
        system_mgmt_interrupt_n_out <= #37 !smi_cmd_in;
    end
endmodule : system_logic_model
`default_nettype wire

// ### test_sleep_smm_ctrl.sv
// self-checking bench for the sleep and management-mode control block
// assumes the system logic model in front of the request pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t mismatch at line %0d", $time, `__LINE__); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 60) begin @(negedge core_clk_in); k++; end \
    if (k >= 60) begin err_total++; finish_test(); end end
module test_sleep_smm_ctrl;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic core_clk_in = 0, nrst_in = 0, halt_cmd = 0, sleep_cmd = 0, smi_cmd = 0;
    logic snoop_req_in = 0, intr_req_in = 0, handler_exit_in = 0;
    wire logic sleep_request_n_in, core_clock_halt_request_n_in, system_mgmt_interrupt_n_in;
    logic core_clk_en_out, bus_clk_en_out, intr_clk_en_out, pll_run_out, grant_ack_out;
    logic mgmt_ack_out, save_state_out, handler_fetch_out, system_management_mode_out;
    logic snoop_accept_out, intr_accept_out, intr_service_out, sleeping_out;
    int   err_total = 0, n_compared = 0, k;
    always #50 core_clk_in = ~core_clk_in;
    sleep_smm_ctrl uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .sleep_request_n_in(sleep_request_n_in),
        .core_clock_halt_request_n_in(core_clock_halt_request_n_in),
        .system_mgmt_interrupt_n_in(system_mgmt_interrupt_n_in), .snoop_req_in(snoop_req_in),
        .intr_req_in(intr_req_in), .handler_exit_in(handler_exit_in),
        .core_clk_en_out(core_clk_en_out), .bus_clk_en_out(bus_clk_en_out),
        .intr_clk_en_out(intr_clk_en_out), .pll_run_out(pll_run_out),
        .grant_ack_out(grant_ack_out), .mgmt_ack_out(mgmt_ack_out),
        .save_state_out(save_state_out), .handler_fetch_out(handler_fetch_out),
        .system_management_mode_out(system_management_mode_out),
        .snoop_accept_out(snoop_accept_out), .intr_accept_out(intr_accept_out),
        .intr_service_out(intr_service_out), .sleeping_out(sleeping_out));
    system_logic_model partner (.core_clk_in(core_clk_in), .halt_cmd_in(halt_cmd),
        .sleep_cmd_in(sleep_cmd), .smi_cmd_in(smi_cmd), .grant_ack_in(grant_ack_out),
        .sleep_request_n_out(sleep_request_n_in),
        .core_clock_halt_request_n_out(core_clock_halt_request_n_in),
        .system_mgmt_interrupt_n_out(system_mgmt_interrupt_n_in));
    task automatic finish_test;
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic probe(input logic exp);
        @(posedge core_clk_in);
        snoop_req_in <= 1'h1;
        intr_req_in  <= 1'h1;
        @(posedge core_clk_in);
        snoop_req_in <= 1'h0;
        intr_req_in  <= 1'h0;
        @(negedge core_clk_in);
        `CHK(snoop_accept_out, exp)
        `CHK(intr_accept_out, exp)
    endtask : probe
    task automatic t_halt_sleep;
        @(posedge core_clk_in) halt_cmd <= 1'h1;
        `WAIT(grant_ack_out)
        `CHK({core_clk_en_out, bus_clk_en_out, intr_clk_en_out}, 3'h3)
        probe(1'h1);
        @(posedge core_clk_in) sleep_cmd <= 1'h1;
        `WAIT(sleeping_out)
        `CHK({core_clk_en_out, bus_clk_en_out, intr_clk_en_out, pll_run_out}, 4'h1)
        probe(1'h0);
        // a management request during sleep must be dropped
        @(posedge core_clk_in) smi_cmd <= 1'h1;
        repeat (8) @(negedge core_clk_in);
        `CHK({sleeping_out, save_state_out}, 2'h2)
        @(posedge core_clk_in) smi_cmd <= 1'h0;
        sleep_cmd <= 1'h0;
        `WAIT(!sleeping_out)
        `CHK({core_clk_en_out, bus_clk_en_out, intr_clk_en_out}, 3'h3)
        @(posedge core_clk_in) halt_cmd <= 1'h0;
        `WAIT(core_clk_en_out)
        `CHK({bus_clk_en_out, save_state_out, sleeping_out}, 3'h4)
        // interrupt latched in grant is serviced one cycle after run resumes
        @(negedge core_clk_in);
        `CHK(intr_service_out, 1'h1)
    endtask : t_halt_sleep
    task automatic t_mgmt;
        @(posedge core_clk_in) smi_cmd <= 1'h1;
        `WAIT(save_state_out)
        @(posedge core_clk_in) smi_cmd <= 1'h0;
        k = 1;
        while (save_state_out && k < 20) begin
            @(negedge core_clk_in);
            k++;
        end
        `CHK(k, 9)
        `CHK({mgmt_ack_out, system_management_mode_out}, 2'h3)
        @(negedge core_clk_in);
        `CHK({handler_fetch_out, mgmt_ack_out}, 2'h2)
        @(posedge core_clk_in) handler_exit_in <= 1'h1;
        @(posedge core_clk_in) handler_exit_in <= 1'h0;
        `WAIT(!system_management_mode_out)
        `CHK(handler_fetch_out, 1'h0)
    endtask : t_mgmt
    initial begin
        repeat (12) @(posedge core_clk_in);
        nrst_in <= 1'h1;
        @(negedge core_clk_in);
        `CHK({core_clk_en_out, bus_clk_en_out, pll_run_out, sleeping_out}, 4'he)
        t_halt_sleep();
        t_mgmt();
        t_halt_sleep();
        finish_test();
    end
endmodule : test_sleep_smm_ctrl
`default_nettype wire
